// file: bpcs_pkg.sv
// Overview of operation
// - Sink three current is (step count plus one) times selected step size.
// - Boot period select picks 80, 120, 220 or 420 ms boot period.
// - Boot engine enables features with sequence code 010, 011, 100, spaced by delay.
// - Retry clear: undervoltage during boot with charger latches off until charger removed.
// - Retry set: undervoltage during boot waits retry timeout, reboots if charger present.
`default_nettype none
package bpcs_pkg;
    localparam logic [7:0] ADDR_PFN_STATUS = 8'h7D;
    localparam logic [7:0] ADDR_BOOT_CFG   = 8'h7E;
    localparam logic [7:0] ADDR_PWR_CFG    = 8'h7F;
    localparam logic [7:0] ADDR_SINK_CFG   = 8'h7C;
    localparam logic [7:0] ADDR_SEQ_STATE  = 8'h90;
    localparam int         SINK_CNT_LSB    = 0;
    localparam int         SINK_SEL_LSB    = 5;
    localparam int         BOOT_RETRY_BIT  = 0;
    localparam int         BOOT_DLY_LSB    = 1;
    localparam int         KEEPALIVE_BIT   = 0;
    localparam logic [7:0] SINK_CFG_RESET  = 8'h00;
    localparam logic [2:0] BOOT_CFG_RESET  = 3'h0;
    localparam int         CLK_HZ          = 125_000_000;
    localparam int         BOOT_MS_0       = 80;
    localparam int         BOOT_MS_1       = 120;
    localparam int         BOOT_MS_2       = 220;
    localparam int         BOOT_MS_3       = 420;
    localparam int         RETRY_MS        = 1000;
    localparam int         KEEPALIVE_MS    = 5000;
    localparam int         CYC_PER_MS      = CLK_HZ / 1000;
    localparam logic [2:0] SEQ_STAGE_A     = 3'h2;
    localparam logic [2:0] SEQ_STAGE_B     = 3'h3;
    localparam logic [2:0] SEQ_STAGE_C     = 3'h4;
    // Step sizes in tenths of a milliamp
    localparam logic [3:0] STEP_DMA_0      = 4'h6;
    localparam logic [3:0] STEP_DMA_1      = 4'hA;
    localparam logic [3:0] STEP_DMA_2      = 4'hC;
endpackage : bpcs_pkg
`default_nettype wire

// file: bpcs_sink_current.sv
`timescale 1ns/1ns
`default_nettype none
module bpcs_sink_current (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    // Setting
    input  wire logic [4:0] step_count_i,
    input  wire logic [1:0] step_select_i,
    // Current in tenths of a milliamp
    output logic      [8:0] current_dma_o
);
    logic [3:0] step;
    always_comb begin
        case (step_select_i)
            2'h0:    step = bpcs_pkg::STEP_DMA_0;
            2'h1:    step = bpcs_pkg::STEP_DMA_1;
            default: step = bpcs_pkg::STEP_DMA_2;
        endcase
    end
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            current_dma_o <= 9'h000;
        end else begin
            current_dma_o <= (9'(step_count_i) + 9'h001) * 9'(step);
        end
    end
    property p_sink_current;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rstn_i |=> current_dma_o == (9'($past(step_count_i)) + 9'h001) * 9'($past(step));
    endproperty
    a_sink_current: assert property (p_sink_current) else $error("sink current wrong");
endmodule : bpcs_sink_current
`default_nettype wire

// file: bpcs_boot_power.sv
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module bpcs_boot_power #(
    parameter int BOOT_MS_CYC   = bpcs_pkg::CYC_PER_MS,
    parameter int RETRY_CYC     = bpcs_pkg::RETRY_MS * bpcs_pkg::CYC_PER_MS,
    parameter int KEEPALIVE_CYC = bpcs_pkg::KEEPALIVE_MS * bpcs_pkg::CYC_PER_MS,
    parameter int FEAT_N        = 4
) (
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   wb_err_o,
    // Board and power state
    input  wire logic              charger_input_present_i,
    input  wire logic              undervoltage_lockout_i,
    input  wire logic              power_func_pin_one_state_i,
    input  wire logic              power_func_pin_two_state_i,
    input  wire logic [2:0]        boot_period_select_strap_i,
    input  wire logic [3*FEAT_N-1:0] feature_seq_i,
    // Outputs
    output logic [FEAT_N-1:0]      feature_enable_o,
    output logic                   power_on_o,
    output logic                   latched_off_o,
    output logic [8:0]             sink_three_current_o
);
    typedef enum logic [2:0] {
        BPCS_OFF, BPCS_BOOT, BPCS_RUN, BPCS_RETRY, BPCS_LATCH
    } bpcs_state_e;

    function automatic logic [31:0] bpcs_boot_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    return 32'(bpcs_pkg::BOOT_MS_0 * BOOT_MS_CYC);
            2'h1:    return 32'(bpcs_pkg::BOOT_MS_1 * BOOT_MS_CYC);
            2'h2:    return 32'(bpcs_pkg::BOOT_MS_2 * BOOT_MS_CYC);
            default: return 32'(bpcs_pkg::BOOT_MS_3 * BOOT_MS_CYC);
        endcase
    endfunction : bpcs_boot_cycles

    function automatic logic bpcs_stage_due(input logic [2:0]  code,
                                            input logic        run,
                                            input logic [31:0] t,
                                            input logic [31:0] len);
        case (code)
            bpcs_pkg::SEQ_STAGE_A: return 1'b1;
            bpcs_pkg::SEQ_STAGE_B: return run || t >= (len >> 2);
            bpcs_pkg::SEQ_STAGE_C: return run || t >= (len >> 1);
            default:               return 1'b0;
        endcase
    endfunction : bpcs_stage_due

    bpcs_state_e state_reg;
    logic [31:0] timer_reg;
    logic [31:0] ka_timer_reg;
    logic [2:0]  boot_cfg_reg;
    logic        strap_taken_reg;
    logic        keepalive_reg;
    logic [7:0]  sink_cfg_reg;
    logic [31:0] rdata;
    logic        hit;
    logic        req;
    logic        boot_retry;
    logic [1:0]  boot_sel;
    logic [31:0] boot_len;
    logic [8:0]  sink_current;

    assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign boot_retry = boot_cfg_reg[bpcs_pkg::BOOT_RETRY_BIT];
    assign boot_sel   = boot_cfg_reg[bpcs_pkg::BOOT_DLY_LSB +: 2];
    assign boot_len   = bpcs_boot_cycles(boot_sel);

    // Boot config is read-only; captured from straps after reset release
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_cfg_reg    <= bpcs_pkg::BOOT_CFG_RESET;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            boot_cfg_reg    <= boot_period_select_strap_i;
            strap_taken_reg <= 1'b1;
        end
    end

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            bpcs_pkg::ADDR_PFN_STATUS: rdata[1:0] = {power_func_pin_two_state_i,
                                                     power_func_pin_one_state_i};
            bpcs_pkg::ADDR_BOOT_CFG:   rdata[2:0] = boot_cfg_reg;
            bpcs_pkg::ADDR_PWR_CFG:    rdata[0]   = keepalive_reg;
            bpcs_pkg::ADDR_SINK_CFG:   rdata[7:0] = sink_cfg_reg;
            bpcs_pkg::ADDR_SEQ_STATE:  rdata[2:0] = 3'(state_reg);
            default:                   hit        = 1'b0;
        endcase
    end

    // Single-cycle ack; unmapped addresses answer with err
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            wb_dat_o <= (req && hit && !wb_we_i) ? rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sink_cfg_reg <= bpcs_pkg::SINK_CFG_RESET;
        end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == bpcs_pkg::ADDR_SINK_CFG) begin
            sink_cfg_reg <= wb_dat_i[7:0];
        end
    end

    // Keepalive cleared in OFF and LATCH (not in RETRY) so a power-on from OFF must confirm again
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            keepalive_reg <= 1'b0;
        end else if (state_reg == BPCS_OFF || state_reg == BPCS_LATCH) begin
            keepalive_reg <= 1'b0;
        end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == bpcs_pkg::ADDR_PWR_CFG) begin
            keepalive_reg <= wb_dat_i[bpcs_pkg::KEEPALIVE_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg    <= BPCS_OFF;
            timer_reg    <= 32'h0000_0000;
            ka_timer_reg <= 32'h0000_0000;
        end else begin
            case (state_reg)
                BPCS_OFF: begin
                    timer_reg    <= 32'h0000_0000;
                    ka_timer_reg <= 32'h0000_0000;
                    if (charger_input_present_i && !undervoltage_lockout_i && strap_taken_reg) begin
                        state_reg <= BPCS_BOOT;
                    end
                end
                BPCS_BOOT: begin
                    timer_reg    <= timer_reg + 32'h0000_0001;
                    ka_timer_reg <= ka_timer_reg + 32'h0000_0001;
                    if (undervoltage_lockout_i && charger_input_present_i) begin
                        timer_reg <= 32'h0000_0000;
                        state_reg <= boot_retry ? BPCS_RETRY : BPCS_LATCH;
                    end else if (undervoltage_lockout_i) begin
                        state_reg <= BPCS_OFF;
                    end else if (timer_reg >= boot_len - 32'h0000_0001) begin
                        state_reg <= BPCS_RUN;
                    end
                end
                BPCS_RUN: begin
                    if (ka_timer_reg < 32'(KEEPALIVE_CYC)) begin
                        ka_timer_reg <= ka_timer_reg + 32'h0000_0001;
                    end
                    if (undervoltage_lockout_i ||
                        (!keepalive_reg && ka_timer_reg >= 32'(KEEPALIVE_CYC - 1))) begin
                        state_reg <= BPCS_OFF;
                    end
                end
                BPCS_RETRY: begin
                    timer_reg <= timer_reg + 32'h0000_0001;
                    if (timer_reg >= 32'(RETRY_CYC - 1)) begin
                        timer_reg    <= 32'h0000_0000;
                        ka_timer_reg <= 32'h0000_0000;
                        state_reg    <= charger_input_present_i ? BPCS_BOOT : BPCS_OFF;
                    end
                end
                BPCS_LATCH: begin
                    if (!charger_input_present_i) begin
                        state_reg <= BPCS_OFF;
                    end
                end
                default: state_reg <= BPCS_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            feature_enable_o <= '0;
        end else begin
            for (int i = 0; i < FEAT_N; i++) begin
                if (state_reg != BPCS_BOOT && state_reg != BPCS_RUN) begin
                    feature_enable_o[i] <= 1'b0;
                end else if (bpcs_stage_due(feature_seq_i[3*i +: 3], state_reg == BPCS_RUN,
                                            timer_reg, boot_len)) begin
                    feature_enable_o[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            power_on_o           <= 1'b0;
            latched_off_o        <= 1'b0;
            sink_three_current_o <= 9'h000;
        end else begin
            power_on_o           <= state_reg == BPCS_BOOT || state_reg == BPCS_RUN;
            latched_off_o        <= state_reg == BPCS_LATCH;
            sink_three_current_o <= sink_current;
        end
    end

    bpcs_sink_current u_sink (
        .clk_sys_i     (clk_sys_i),
        .rstn_i        (rstn_i),
        .step_count_i  (sink_cfg_reg[bpcs_pkg::SINK_CNT_LSB +: 5]),
        .step_select_i (sink_cfg_reg[bpcs_pkg::SINK_SEL_LSB +: 2]),
        .current_dma_o (sink_current)
    );

    property p_latch_hold;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_LATCH && charger_input_present_i) |=> state_reg == BPCS_LATCH;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch left early");

    property p_uv_latch;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_BOOT && undervoltage_lockout_i && charger_input_present_i
         && !boot_retry) |=> state_reg == BPCS_LATCH;
    endproperty
    a_uv_latch: assert property (p_uv_latch) else $error("no latch on undervoltage_lockout");

    property p_uv_retry;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_BOOT && undervoltage_lockout_i && charger_input_present_i
         && boot_retry) |=> state_reg == BPCS_RETRY && timer_reg == 32'h0;
    endproperty
    a_uv_retry: assert property (p_uv_retry) else $error("no retry on undervoltage_lockout");

    property p_boot_end;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_BOOT && !undervoltage_lockout_i
         && timer_reg < boot_len - 32'h1) |=> state_reg == BPCS_BOOT;
    endproperty
    a_boot_end: assert property (p_boot_end) else $error("boot ended early");

    property p_stage_a;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_BOOT && feature_seq_i[2:0] == bpcs_pkg::SEQ_STAGE_A)
        |=> feature_enable_o[0];
    endproperty
    a_stage_a: assert property (p_stage_a) else $error("stage a not on");

    property p_no_ka_off;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_RUN && !undervoltage_lockout_i && keepalive_reg)
        |=> state_reg == BPCS_RUN;
    endproperty
    a_no_ka_off: assert property (p_no_ka_off) else $error("shut down with keepalive");

    property p_power_out;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        state_reg == BPCS_LATCH |=> !power_on_o && latched_off_o;
    endproperty
    a_power_out: assert property (p_power_out) else $error("power out wrong");

    property p_ack_one;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");

    property p_stage_b_wait;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_BOOT && feature_seq_i[5:3] == bpcs_pkg::SEQ_STAGE_B
         && timer_reg < (boot_len >> 2)) |-> !feature_enable_o[1];
    endproperty
    a_stage_b_wait: assert property (p_stage_b_wait) else $error("stage b early");

    property p_stage_c;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_BOOT && feature_seq_i[8:6] == bpcs_pkg::SEQ_STAGE_C
         && timer_reg >= (boot_len >> 1)) |=> feature_enable_o[2];
    endproperty
    a_stage_c: assert property (p_stage_c) else $error("stage c not on");

    property p_latch_release;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_reg == BPCS_LATCH && !charger_input_present_i) |=> state_reg == BPCS_OFF;
    endproperty
    a_latch_release: assert property (p_latch_release) else $error("latch kept");

    sequence s_retry_done;
        state_reg == BPCS_RETRY && timer_reg >= 32'(RETRY_CYC - 1);
    endsequence
    property p_retry_reboot;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        s_retry_done ##0 charger_input_present_i |=> state_reg == BPCS_BOOT;
    endproperty
    a_retry_reboot: assert property (p_retry_reboot) else $error("no reboot");

    sequence s_ka_expire;
        state_reg == BPCS_RUN && !undervoltage_lockout_i && !keepalive_reg
        && ka_timer_reg >= 32'(KEEPALIVE_CYC - 1);
    endsequence
    sequence s_power_drop;
        state_reg == BPCS_OFF ##1 !power_on_o;
    endsequence
    property p_ka_off;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        s_ka_expire |=> s_power_drop;
    endproperty
    a_ka_off: assert property (p_ka_off) else $error("no shutdown");
endmodule : bpcs_boot_power
`default_nettype wire

// file: boot_power_config_status_test.sv
`timescale 1ns/1ns
`default_nettype none
module boot_power_config_status_test;
    localparam int MS_CYC    = 10;
    localparam int RETRY_CYC = 50;
    localparam int KEEP_CYC  = 5000;
    logic        clk_sys_i;
    logic        rstn_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        err;
    logic        chg;
    logic        undervoltage_lockout;
    logic        pf1;
    logic        pf2;
    logic [2:0]  strap;
    logic [11:0] seq;
    logic [3:0]  feat;
    logic        pwr;
    logic        latched;
    logic [8:0]  cur;
    int          miscompares;
    int          tests_run;
    logic [31:0] q;
    logic        e;
    logic [1:0]  dly;
    logic [4:0]  c;
    logic [1:0]  s;
    int          blen;

    bpcs_boot_power #(.BOOT_MS_CYC(MS_CYC), .RETRY_CYC(RETRY_CYC), .KEEPALIVE_CYC(KEEP_CYC),
                      .FEAT_N(4)) bpcs_boot_power_i (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .charger_input_present_i(chg), .undervoltage_lockout_i(undervoltage_lockout),
        .power_func_pin_one_state_i(pf1), .power_func_pin_two_state_i(pf2),
        .boot_period_select_strap_i(strap), .feature_seq_i(seq), .feature_enable_o(feat),
        .power_on_o(pwr), .latched_off_o(latched), .sink_three_current_o(cur));

    always #4 clk_sys_i = ~clk_sys_i;

    function automatic int boot_len(input logic [1:0] d);
        case (d)
            2'h0: return bpcs_pkg::BOOT_MS_0 * MS_CYC;
            2'h1: return bpcs_pkg::BOOT_MS_1 * MS_CYC;
            2'h2: return bpcs_pkg::BOOT_MS_2 * MS_CYC;
            default: return bpcs_pkg::BOOT_MS_3 * MS_CYC;
        endcase
    endfunction : boot_len

    function automatic logic [8:0] sink_exp(input logic [4:0] cn, input logic [1:0] sl);
        logic [3:0] st;
        st = (sl == 2'h0) ? 4'h6 : (sl == 2'h1) ? 4'hA : 4'hC;
        return (9'(cn) + 9'h001) * 9'(st);
    endfunction : sink_exp

    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    // Classic single cycle; request held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] sl);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= sl;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            check(32'h0, 32'h1, "bus answer");
            finish_test();
        end
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        wb(1'b0, a, 32'h0, 4'h1);
        check(q & m, x, "register read");
    endtask : rd

    task automatic do_reset(input logic [2:0] st);
        rstn_i <= 1'b0;
        strap <= st;
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
    endtask : do_reset

    task automatic wait_pwr(input logic v, input int lim);
        int n;
        n = 0;
        while (pwr !== v && n < lim) begin
            @(posedge clk_sys_i);
            n++;
        end
        check(32'(pwr), 32'(v), "power state");
    endtask : wait_pwr

    task automatic uv_pulse();
        repeat (blen / 8) @(posedge clk_sys_i);
        undervoltage_lockout <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        undervoltage_lockout <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask : uv_pulse

    initial begin
        repeat (3 * KEEP_CYC + 4 * bpcs_pkg::BOOT_MS_3 * MS_CYC + 2000) @(posedge clk_sys_i);
        miscompares++;
        finish_test();
    end

    initial begin
        {clk_sys_i, rstn_i, cyc, stb, we, chg, undervoltage_lockout, pf1, pf2} = 9'h000;
        {adr, sel, wdat, strap} = 47'h0;
        seq = {3'h0, 3'h4, 3'h3, 3'h2};
        miscompares = 0;
        tests_run = 0;
        void'($urandom(32'h6603));
        dly = 2'($urandom_range(3));
        blen = boot_len(dly);
        do_reset({dly, 1'b0});
        check(32'(feat), 32'h0, "features off");
        rd(bpcs_pkg::ADDR_BOOT_CFG, 32'h7, {29'h0, dly, 1'b0});
        wb(1'b1, bpcs_pkg::ADDR_BOOT_CFG, 32'hFF, 4'h1);
        rd(bpcs_pkg::ADDR_BOOT_CFG, 32'h7, {29'h0, dly, 1'b0});
        for (int i = 0; i < 4; i++) begin
            pf1 <= i[0];
            pf2 <= i[1];
            repeat (4) @(posedge clk_sys_i);
            rd(bpcs_pkg::ADDR_PFN_STATUS, 32'hFFFFFFFF, 32'(i));
        end
        for (int k = 0; k < 3; k++) begin
            wb(1'b0, (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : 8'h91, 32'h0, 4'h1);
            check(32'(e), 32'h1, "unmapped error");
        end
        for (int i = 0; i < 24; i++) begin
            c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
            s = 2'(i);
            wb(1'b1, bpcs_pkg::ADDR_SINK_CFG, {25'h0, s, c}, 4'h1);
            rd(bpcs_pkg::ADDR_SINK_CFG, 32'h7F, {25'h0, s, c});
            repeat (3) @(posedge clk_sys_i);
            check(32'(cur), 32'(sink_exp(c, s)), "sink current");
        end
        wb(1'b1, bpcs_pkg::ADDR_SINK_CFG, 32'h00, 4'h0);
        rd(bpcs_pkg::ADDR_SINK_CFG, 32'h7F, {25'h0, s, c});
        chg <= 1'b1;
        wait_pwr(1'b1, 20);
        rd(bpcs_pkg::ADDR_SEQ_STATE, 32'h7, 32'h1);
        repeat (blen / 8 - 3) @(posedge clk_sys_i);
        check(32'(feat), 32'h1, "first stage");
        repeat (blen / 4) @(posedge clk_sys_i);
        check(32'(feat), 32'h3, "second stage");
        repeat (3 * blen / 8) @(posedge clk_sys_i);
        check(32'(feat), 32'h7, "third stage");
        repeat (blen / 4 - 30) @(posedge clk_sys_i);
        rd(bpcs_pkg::ADDR_SEQ_STATE, 32'h7, 32'h1);
        repeat (35) @(posedge clk_sys_i);
        rd(bpcs_pkg::ADDR_SEQ_STATE, 32'h7, 32'h2);
        repeat (KEEP_CYC - blen - 40) @(posedge clk_sys_i);
        check(32'(pwr), 32'h1, "on before keepalive limit");
        wait_pwr(1'b0, 60);
        check(32'(feat), 32'h0, "features off after shutdown");
        wait_pwr(1'b1, 20);
        wb(1'b1, bpcs_pkg::ADDR_PWR_CFG, 32'h01, 4'h1);
        rd(bpcs_pkg::ADDR_PWR_CFG, 32'hFF, 32'h01);
        repeat (KEEP_CYC + 100) @(posedge clk_sys_i);
        check(32'(pwr), 32'h1, "kept alive");
        undervoltage_lockout <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check(32'(pwr), 32'h0, "undervoltage ends run");
        undervoltage_lockout <= 1'b0;
        do_reset({dly, 1'b0});
        wait_pwr(1'b1, 20);
        uv_pulse();
        check(32'({latched, pwr}), 32'h2, "latched off");
        repeat (RETRY_CYC * 4) @(posedge clk_sys_i);
        check(32'({latched, pwr}), 32'h2, "still latched");
        rd(bpcs_pkg::ADDR_SEQ_STATE, 32'h7, 32'h4);
        chg <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        check(32'({latched, pwr}), 32'h0, "released by charger removal");
        dly = 2'($urandom_range(3));
        blen = boot_len(dly);
        do_reset({dly, 1'b1});
        chg <= 1'b1;
        wait_pwr(1'b1, 20);
        uv_pulse();
        check(32'({latched, pwr}), 32'h0, "retry wait");
        rd(bpcs_pkg::ADDR_SEQ_STATE, 32'h7, 32'h3);
        repeat (RETRY_CYC - 20) @(posedge clk_sys_i);
        check(32'(pwr), 32'h0, "off during retry wait");
        wait_pwr(1'b1, 40);
        uv_pulse();
        chg <= 1'b0;
        repeat (RETRY_CYC + 20) @(posedge clk_sys_i);
        check(32'(pwr), 32'h0, "no reboot without charger");
        rd(bpcs_pkg::ADDR_SEQ_STATE, 32'h7, 32'h0);
        finish_test();
    end
endmodule : boot_power_config_status_test
`default_nettype wire
